// ### shared/power_pin_map.vh
// constants for the power state pin controller
// assumes a single 200 MHz clock and plain Verilog-2005 includers
`ifndef POWER_PIN_MAP_VH
`define POWER_PIN_MAP_VH
// core voltage select default code (both bits high)
`define VOLT_SEL_DEFAULT 2'h3
// power state request encoding
`define PSTATE_S0 2'h0
`define PSTATE_SX 2'h1
`define PSTATE_DEEP 2'h2
// reset request figures
`define CLK_PERIOD_PS 5000
`define RESET_MIN_NS 100
`define RESET_MIN_CYCLES ((`RESET_MIN_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ### rtl/level_sync.v
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit changes slowly compared with the clock
module level_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input wire ref_clk_i,
	input wire reset_i,
	input wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] stage_a;
	reg [WIDTH-1:0] stage_b;

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			stage_a <= INIT;
			stage_b <= INIT;
		end else begin
			stage_a <= async_i;
			stage_b <= stage_a;
		end
	end

	assign sync_o = stage_b;
endmodule // level_sync

// ### rtl/power_state_pin_control.v
// pin-level power state control: status inputs in, rail and reset controls out
// assumes status pins are asynchronous and policy inputs come from same-clock logic
// Operation
// - while battery low is seen, no wake from sleep and no exit from deep sleep occur.
// - when enabled, the assertion of battery low raises a one-cycle management interrupt.
// - deep sleep policy uses AC presence and can allow deep sleep only on battery.
// - in default mode both core voltage select bits are driven high.
// - in override mode the two core voltage select bits carry the requested aux input rail voltage code.
// - the external power gate output is asserted during the deepest processor idle state.
// - the memory reset is an active-low open-drain output.
// - deep well power good marks the deep well supply as valid.
// - platform reset is asserted whenever core power good is low.
// - platform reset is low in sleep, in deep sleep and while a system reset is requested, released RESET_MIN_CYCLES + 1 cycles after the last cause clears.
`include "power_pin_map.vh"
module power_state_pin_control #(
	parameter RESET_MIN_CYCLES = `RESET_MIN_CYCLES
) (
	input wire ref_clk_i,
	input wire reset_i,
	input wire ac_power_present_i,
	input wire battery_low_n_i,
	input wire deep_well_power_good_i,
	input wire core_power_good_i,
	input wire sleep_req_i,
	input wire wake_req_i,
	input wire deep_idle_req_i,
	input wire sys_reset_req_i,
	input wire low_battery_irq_en_i,
	input wire deep_sleep_en_i,
	input wire deep_sleep_battery_only_i,
	input wire volt_sel_override_i,
	input wire [1:0] volt_sel_code_i,
	input wire mem_reset_req_i,
	output reg [1:0] power_state_o,
	output reg sys_mgmt_interrupt_o,
	output reg core_volt_sel_b0_o,
	output reg core_volt_sel_b1_o,
	output reg deep_idle_power_gate_n_o,
	output reg platform_reset_n_o,
	output wire mem_reset_n_o,
	output wire mem_reset_n_oe_n_o
);
	// ==========================================================
	// input synchronisers
	wire [3:0] pin_sync;
	wire ac_ok;
	wire batt_low;
	wire deep_ok;
	wire core_ok;

	level_sync #(
		.WIDTH(4),
		.INIT(4'h2)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.async_i({core_power_good_i, deep_well_power_good_i, battery_low_n_i,
			ac_power_present_i}),
		.sync_o(pin_sync)
	);

	// status pins come from other wells and pass two stages before any use
	localparam SYNC_AC = 0;
	localparam SYNC_BATT = 1;
	localparam SYNC_DEEP = 2;
	localparam SYNC_CORE = 3;

	assign ac_ok = pin_sync[SYNC_AC];
	assign batt_low = ~pin_sync[SYNC_BATT];
	assign deep_ok = pin_sync[SYNC_DEEP];
	assign core_ok = pin_sync[SYNC_CORE];

	// ==========================================================
	// power state machine
	localparam [2:0] ST_S0 = 3'h1;
	localparam [2:0] ST_SX = 3'h2;
	localparam [2:0] ST_DEEP = 3'h4;

	// ==========================================================
	// decoding helpers
	// a wake step needs the request, no low battery and the target rail good
	function wake_allowed;
		input wake;
		input low;
		input rail_good;
		begin
			wake_allowed = wake & ~low & rail_good;
		end
	endfunction

	// one-hot state to the power state code seen on the output
	function [1:0] state_code;
		input [2:0] st;
		begin
			case (st)
				ST_S0: state_code = `PSTATE_S0;
				ST_DEEP: state_code = `PSTATE_DEEP;
				default: state_code = `PSTATE_SX;
			endcase
		end
	endfunction

	reg [2:0] state;
	reg [2:0] next_state;
	reg batt_low_q;
	wire deep_allowed;

	// on battery only mode forbids deep sleep while AC is present
	assign deep_allowed = deep_sleep_en_i & deep_ok
		& ~(deep_sleep_battery_only_i & ac_ok);

	always @* begin
		next_state = state;
		case (state)
			ST_S0: begin
				if (sleep_req_i)
					next_state = ST_SX;
			end
			ST_SX: begin
				// an allowed wake wins over deep sleep entry
				if (wake_allowed(wake_req_i, batt_low, core_ok))
					next_state = ST_S0;
				else if (deep_allowed)
					next_state = ST_DEEP;
			end
			ST_DEEP: begin
				if (wake_allowed(wake_req_i, batt_low, deep_ok))
					next_state = ST_SX;
			end
			default: next_state = ST_SX;
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			// the platform starts asleep until a wake is seen
			state <= ST_SX;
			batt_low_q <= 1'b0;
			sys_mgmt_interrupt_o <= 1'b0;
		end else begin
			state <= next_state;
			batt_low_q <= batt_low;
			// rising edge of batt_low only: a battery left low does not repeat the interrupt
			sys_mgmt_interrupt_o <= batt_low & ~batt_low_q & low_battery_irq_en_i;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i)
			power_state_o <= `PSTATE_SX;
		else
			power_state_o <= state_code(next_state);
	end

	// ==========================================================
	// platform reset with minimum hold
	// the hold gives a clean low time after the last cause clears
	reg [15:0] hold_cnt;
	wire reset_cause;

	assign reset_cause = ~core_ok | (state != ST_S0) | (next_state != ST_S0)
		| sys_reset_req_i;

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			platform_reset_n_o <= 1'b0;
			hold_cnt <= 16'h0000;
		end else if (reset_cause) begin
			platform_reset_n_o <= 1'b0;
			hold_cnt <= RESET_MIN_CYCLES[15:0];
		end else if (hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;
		end else begin
			platform_reset_n_o <= 1'b1;
		end
	end

	// ==========================================================
	// core voltage select
	localparam [1:0] VOLT_DEFAULT = `VOLT_SEL_DEFAULT;

	// override hands the requested aux rail code straight to the regulator
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			core_volt_sel_b0_o <= VOLT_DEFAULT[0];
			core_volt_sel_b1_o <= VOLT_DEFAULT[1];
		end else if (volt_sel_override_i) begin
			core_volt_sel_b0_o <= volt_sel_code_i[0];
			core_volt_sel_b1_o <= volt_sel_code_i[1];
		end else begin
			core_volt_sel_b0_o <= VOLT_DEFAULT[0];
			core_volt_sel_b1_o <= VOLT_DEFAULT[1];
		end
	end

	// ==========================================================
	// external power gate for the deepest idle state
	// the gated rails may drop only while the core is up and in S0
	always @(posedge ref_clk_i) begin
		if (reset_i)
			deep_idle_power_gate_n_o <= 1'b1;
		else
			deep_idle_power_gate_n_o <= ~(deep_idle_req_i & (state == ST_S0)
				& core_ok);
	end

	// ==========================================================
	// memory reset, open drain: only ever pulls low
	// memory is also held in reset while the deep well supply is not valid
	reg mem_reset_drive;

	always @(posedge ref_clk_i) begin
		if (reset_i)
			mem_reset_drive <= 1'b1;
		else
			mem_reset_drive <= mem_reset_req_i | ~deep_ok;
	end

	assign mem_reset_n_o = 1'b0;
	assign mem_reset_n_oe_n_o = ~mem_reset_drive;
endmodule // power_state_pin_control

// ### verification/power_rails_model.sv
// rails, battery and gate circuits seen from the controller pins
// assumes the bench sets the wanted pin levels
module power_rails_model (
	input wire [3:0] want_i,
	input wire gate_n_i,
	input wire mem_data_i,
	input wire mem_oe_n_i,
	output wire [3:0] pins_o,
	output wire mem_line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pins_o = want_i | {!gate_n_i, 3'h0};
	// pull-up to the memory plane when released
	assign mem_line_o = mem_oe_n_i ? 1'b1 : mem_data_i;
endmodule // power_rails_model

// ### verification/power_state_pin_control_chk.sv
// port checker for the power state pin controller
// assumes a single clock with synchronous reset
module power_state_pin_control_chk (
	input wire ref_clk_i,
	input wire reset_i,
	input wire battery_low_n_i,
	input wire deep_well_power_good_i,
	input wire core_power_good_i,
	input wire deep_idle_req_i,
	input wire sys_reset_req_i,
	input wire volt_sel_override_i,
	input wire [1:0] volt_sel_code_i,
	input wire mem_reset_req_i,
	input wire [1:0] power_state_o,
	input wire sys_mgmt_interrupt_o,
	input wire core_volt_sel_b0_o,
	input wire core_volt_sel_b1_o,
	input wire deep_idle_power_gate_n_o,
	input wire platform_reset_n_o,
	input wire mem_reset_n_o,
	input wire mem_reset_n_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	gate_cause_a: assert property (!deep_idle_power_gate_n_o |-> $past(deep_idle_req_i))
		else $error("gate low without idle");
	volt_code_a: assert property (!$past(reset_i) |-> {core_volt_sel_b1_o, core_volt_sel_b0_o}
		== ($past(volt_sel_override_i) ? $past(volt_sel_code_i) : 2'h3)) else $error("volt code");
	core_reset_a: assert property (!core_power_good_i [*4] |-> !platform_reset_n_o)
		else $error("core reset");
	sleep_reset_a: assert property ((power_state_o != 2'h0) [*2] |-> !platform_reset_n_o)
		else $error("sleep reset");
	sys_reset_a: assert property ($past(sys_reset_req_i) |-> !platform_reset_n_o)
		else $error("sys reset");
	low_batt_hold_a: assert property (!battery_low_n_i [*5] |-> power_state_o >= $past(power_state_o))
		else $error("wake on low battery");
	irq_pulse_a: assert property (sys_mgmt_interrupt_o |-> !$past(battery_low_n_i, 3) ##1
		!sys_mgmt_interrupt_o) else $error("irq");
	mem_reset_a: assert property ($past(mem_reset_req_i) |-> !mem_reset_n_oe_n_o && !mem_reset_n_o)
		else $error("mem reset");
	deep_well_a: assert property (!deep_well_power_good_i [*4] |-> !mem_reset_n_oe_n_o)
		else $error("deep well");
	irq_c: cover property (sys_mgmt_interrupt_o);
	gate_c: cover property (!deep_idle_power_gate_n_o);
	deep_c: cover property (power_state_o == 2'h2);
endmodule // power_state_pin_control_chk
bind power_state_pin_control power_state_pin_control_chk i_chk (.*);

// ### verification/power_state_pin_control_test.sv
// self-checking bench for the power state pin controller
// assumes the rail model and the bound checker are compiled alongside
module power_state_pin_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0;
	logic reset_i = 1;
	logic [10:0] c = 0;
	logic [10:0] last = 0;
	logic [3:0] want = 4'hF;
	wire [3:0] p;
	wire [1:0] st;
	wire irq, b0, b1, gate_n, prst_n, mdat, moe_n, mline;
	int fails = 0;
	int checks_done = 0;
	int i;
	power_rails_model i_rails (.want_i(want), .gate_n_i(gate_n), .mem_data_i(mdat),
		.mem_oe_n_i(moe_n), .pins_o(p), .mem_line_o(mline));
	power_state_pin_control #(.RESET_MIN_CYCLES(2)) i_dut (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .ac_power_present_i(p[0]), .battery_low_n_i(p[1]),
		.deep_well_power_good_i(p[2]), .core_power_good_i(p[3]), .sleep_req_i(c[0]),
		.wake_req_i(c[1]), .deep_idle_req_i(c[2]), .sys_reset_req_i(c[3]),
		.low_battery_irq_en_i(c[4]),
		.deep_sleep_en_i(c[5]), .deep_sleep_battery_only_i(c[6]), .volt_sel_override_i(c[7]),
		.volt_sel_code_i(c[9:8]), .mem_reset_req_i(c[10]), .power_state_o(st),
		.sys_mgmt_interrupt_o(irq), .core_volt_sel_b0_o(b0), .core_volt_sel_b1_o(b1),
		.deep_idle_power_gate_n_o(gate_n), .platform_reset_n_o(prst_n), .mem_reset_n_o(mdat),
		.mem_reset_n_oe_n_o(moe_n));
	initial begin
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	task check(input string name, input logic [1:0] exp, input logic [1:0] got);
		checks_done++;
		if (exp !== got) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	function automatic logic [1:0] exp_volt(input logic [10:0] cv);
		return cv[7] ? cv[9:8] : 2'h3;
	endfunction
	task test_done;
		$display("fails %0d checks_done %0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	initial begin
		void'($urandom(98));
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 0;
		tick(1);
		check("state", 2'h1, st);
		check("volt", 2'h3, {b1, b0});
		check("rst", 2'h0, {mline, prst_n});
		@(posedge ref_clk_i);
		c <= 11'h182;
		for (i = 0; i < 60 && prst_n !== 1'b1; i++) tick(1);
		check("state", 2'h0, st);
		check("volt", 2'h1, {b1, b0});
		if (prst_n !== 1'b1) begin
			fails++;
			test_done();
		end
		@(posedge ref_clk_i);
		c <= 11'h010;
		want <= 4'hD;
		tick(3);
		check("irq", 2'h1, {1'b0, irq});
		tick(1);
		check("irq", 2'h0, {1'b0, irq});
		@(posedge ref_clk_i);
		c <= 11'h014;
		tick(1);
		check("gate", 2'h0, {1'b0, gate_n});
		@(posedge ref_clk_i);
		c <= 11'h010;
		want <= 4'h5;
		tick(4);
		check("rst", 2'h0, {1'b0, prst_n});
		repeat (400) begin
			@(posedge ref_clk_i);
			last = c;
			c <= 11'($urandom);
			if ($urandom % 8 == 0)
				want <= 4'($urandom);
			#1;
			check("volt", exp_volt(last), {b1, b0});
			if (last[10])
				check("mem", 2'h0, {mline, moe_n});
			if (last[3])
				check("rst", 2'h0, {1'b0, prst_n});
		end
		test_done();
	end
endmodule // power_state_pin_control_test
